// File: core/plb_checker.sv
// Functional notes
// - Enable bit 0 runs checker, else idle
// - Errored byte count in bits 14-7
// - Single mode: error count stops at FF
// - Writing bit 7 snapshots the counters
// - Writing bit 8 snapshots and clears counters
// - Sync loss latches high at bit 5
// - Bit 4 shows live lock state
// - Total counter overflow sets bit 2
// - Bit 1: continuous one, single zero
// - Sixteen-bit total byte count register
// - Total count captured on bit 7/8 write
// - Single mode: total stops at FFFF
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "plb_regs.svh"

module plb_checker #(
    parameter int LOCK_BYTES = `PLB_LOCK_BYTES,
    parameter int LOSS_BYTES = `PLB_LOSS_BYTES
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire plb_pkg::plb_bus_req_t bus_req,
    input  wire plb_pkg::plb_stream_t  rx,
    output var  logic [15:0]          rd_data
);

    // ==========================================================
    // Shared counter step, saturating or wrapping
    function automatic logic [15:0] plb_bump(
        input logic [15:0] cnt,
        input logic [15:0] max,
        input logic        continuous
    );
        if (cnt == max) begin
            return continuous ? 16'h0000 : max;
        end
        return cnt + 16'h0001;
    endfunction : plb_bump

    // ==========================================================
    // State
    logic        seq_checker_enable;
    logic        checker_count_mode;
    logic        checker_byte_overflow;
    logic        checker_sync_lost;
    logic [7:0]  err_live;
    logic [15:0] total_live;
    logic [7:0]  errored_byte_count;
    logic [15:0] total_byte_count;
    logic        byte_err;
    logic        checker_locked;
    logic        sync_lost_evt;

    // ==========================================================
    // Register port decode
    wire logic hit_ctrl    = (bus_req.addr == `PLB_ADDR_CTRL);
    wire logic hit_total   = (bus_req.addr == `PLB_ADDR_TOTAL);
    wire logic wr_ctrl     = bus_req.wr && hit_ctrl;
    wire logic rd_ctrl     = bus_req.rd && hit_ctrl;
    wire logic rd_total    = bus_req.rd && hit_total;
    // Trigger pulses carried in the error count bit positions
    wire logic clear_pulse = wr_ctrl && bus_req.wdata[`PLB_BIT_CLEAR];
    wire logic snap_pulse  = wr_ctrl && (bus_req.wdata[`PLB_BIT_SNAP]
                                         || bus_req.wdata[`PLB_BIT_CLEAR]);

    // ==========================================================
    // Sequence tracking
    plb_seq_sync #(
        .LOCK_BYTES (LOCK_BYTES),
        .LOSS_BYTES (LOSS_BYTES)
    ) u_seq_sync (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .enable        (seq_checker_enable),
        .rx            (rx),
        .byte_err      (byte_err),
        .locked        (checker_locked),
        .sync_lost_evt (sync_lost_evt)
    );

    // ==========================================================
    // Counter next values
    wire logic        count_byte = seq_checker_enable && rx.valid;
    wire logic        ovf_evt    = count_byte && (total_live == `PLB_TOTAL_MAX);
    wire logic [15:0] total_step = plb_bump(total_live, `PLB_TOTAL_MAX,
                                            checker_count_mode);
    wire logic [15:0] err_step   = plb_bump({8'h00, err_live}, `PLB_ERR_MAX,
                                            checker_count_mode);
    // An event in the clearing cycle is kept as the first count
    wire logic [15:0] next_total = clear_pulse ? (count_byte ? 16'h0001 : 16'h0000)
                                 : count_byte ? total_step : total_live;
    wire logic [7:0]  next_err   = clear_pulse ? (byte_err ? 8'h01 : 8'h00)
                                 : byte_err ? err_step[7:0] : err_live;
    wire logic        next_ovf   = ovf_evt || (checker_byte_overflow && !clear_pulse);
    wire logic        next_lost  = sync_lost_evt
                                 || (checker_sync_lost && !rd_ctrl);

    // ==========================================================
    // Read view of the control and status word
    wire logic [15:0] ctrl_view = {
        1'b0,                     // 15
        errored_byte_count,       // 14-7
        1'b0,                     // 6
        checker_sync_lost,        // 5
        checker_locked,           // 4
        1'b0,                     // 3
        checker_byte_overflow,    // 2
        checker_count_mode,       // 1
        seq_checker_enable        // 0
    };
    wire logic [15:0] next_rd_data = rd_ctrl  ? ctrl_view
                                   : rd_total ? total_byte_count : 16'h0000;

    // Control bits written by software
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seq_checker_enable <= 1'(`PLB_CTRL_RESET);
            checker_count_mode <= 1'b0;
        end else if (wr_ctrl) begin
            seq_checker_enable <= bus_req.wdata[`PLB_BIT_ENABLE];
            checker_count_mode <= bus_req.wdata[`PLB_BIT_MODE];
        end
    end

    // Live counters and sticky status
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            total_live            <= `PLB_TOTAL_RESET;
            err_live              <= `PLB_ERR_RESET;
            checker_byte_overflow <= 1'b0;
            checker_sync_lost     <= 1'b0;
        end else begin
            total_live            <= next_total;
            err_live              <= next_err;
            checker_byte_overflow <= next_ovf;
            checker_sync_lost     <= next_lost;
        end
    end

    // Frozen copies shown to software
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            errored_byte_count <= `PLB_ERR_RESET;
            total_byte_count   <= `PLB_TOTAL_RESET;
        end else if (snap_pulse) begin
            errored_byte_count <= err_live;
            total_byte_count   <= total_live;
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ==========================================================
    // Checks
    sequence s_loss_seen;
        sync_lost_evt;
    endsequence

    sequence s_no_read_two;
        !rd_ctrl [*2];
    endsequence

    property p_loss_held;
        @(posedge ref_clk) disable iff (reset)
        s_loss_seen ##1 s_no_read_two |-> checker_sync_lost;
    endproperty

    a_sync_loss_held: assert property (p_loss_held)
        else $error("sync loss flag not held");

    a_read_clears_loss: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_ctrl && !sync_lost_evt |=> !checker_sync_lost)
        else $error("control read did not clear sync loss");

    a_err_saturates: assert property (
        @(posedge ref_clk) disable iff (reset)
        !checker_count_mode && err_live == 8'hFF && !clear_pulse |=> err_live == 8'hFF)
        else $error("error count left its ceiling");

    a_total_saturates: assert property (
        @(posedge ref_clk) disable iff (reset)
        !checker_count_mode && total_live == 16'hFFFF && !clear_pulse
        |=> total_live == 16'hFFFF)
        else $error("total count left its ceiling");

    a_total_wraps: assert property (
        @(posedge ref_clk) disable iff (reset)
        checker_count_mode && count_byte && total_live == 16'hFFFF && !clear_pulse
        |=> total_live == 16'h0000 && checker_byte_overflow)
        else $error("continuous total did not wrap");

    a_overflow_set: assert property (
        @(posedge ref_clk) disable iff (reset)
        ovf_evt |=> checker_byte_overflow [*2] or (checker_byte_overflow ##1 $past(clear_pulse)))
        else $error("overflow flag not set");

    a_snap_capture: assert property (
        @(posedge ref_clk) disable iff (reset)
        snap_pulse |=> total_byte_count == $past(total_live)
                       && errored_byte_count == $past(err_live))
        else $error("snapshot not captured");

    a_clear_counts: assert property (
        @(posedge ref_clk) disable iff (reset)
        clear_pulse && !count_byte && !byte_err |=> total_live == 16'h0000 && err_live == 8'h00)
        else $error("counters not cleared");

    a_idle_stable: assert property (
        @(posedge ref_clk) disable iff (reset)
        !seq_checker_enable && !clear_pulse ##1 !seq_checker_enable
        |-> $stable(total_live) && !checker_locked)
        else $error("checker active while disabled");

    a_ctrl_readback: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_ctrl |=> rd_data[15] == 1'b0 && rd_data[6] == 1'b0 && rd_data[3] == 1'b0
                    && rd_data[4] == $past(checker_locked)
                    && rd_data[14:7] == $past(errored_byte_count))
        else $error("control word readback wrong");

    // ==========================================================
    // Checks on counting, readback and status causes
    sequence s_clear_write;
        clear_pulse && !count_byte && !byte_err;
    endsequence

    sequence s_counts_zero;
        total_live == 16'h0000 && err_live == 8'h00 && !checker_byte_overflow;
    endsequence

    sequence s_disable_write;
        wr_ctrl && !bus_req.wdata[`PLB_BIT_ENABLE];
    endsequence

    a_clear_all_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        s_clear_write |=> s_counts_zero)
        else $error("clear left counts or overflow");

    a_disable_unlocks: assert property (
        @(posedge ref_clk) disable iff (reset)
        s_disable_write |-> ##2 !checker_locked)
        else $error("lock kept after disable");

    a_total_step: assert property (
        @(posedge ref_clk) disable iff (reset)
        count_byte && !clear_pulse && total_live != 16'hFFFF
        |=> total_live == $past(total_live) + 16'h0001)
        else $error("total count missed a byte");

    a_err_step: assert property (
        @(posedge ref_clk) disable iff (reset)
        byte_err && !clear_pulse && err_live != 8'hFF
        |=> err_live == $past(err_live) + 8'h01)
        else $error("error count missed a byte");

    a_lock_needs_enable: assert property (
        @(posedge ref_clk) disable iff (reset)
        checker_locked |-> $past(seq_checker_enable))
        else $error("locked while disabled");

    a_loss_unlocks: assert property (
        @(posedge ref_clk) disable iff (reset)
        sync_lost_evt |-> !checker_locked)
        else $error("lock kept after sync loss");

    a_mode_write: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_ctrl |=> seq_checker_enable == $past(bus_req.wdata[`PLB_BIT_ENABLE])
                    && checker_count_mode == $past(bus_req.wdata[`PLB_BIT_MODE]))
        else $error("control bits not written");

    a_ovf_cause: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(checker_byte_overflow) |-> $past(ovf_evt))
        else $error("overflow set without event");

    a_loss_cause: assert property (
        @(posedge ref_clk) disable iff (reset)
        $rose(checker_sync_lost) |-> $past(sync_lost_evt))
        else $error("sync loss set without event");

    a_snap_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !snap_pulse |=> $stable(total_byte_count) && $stable(errored_byte_count))
        else $error("snapshot changed without trigger");

    a_total_readback: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_total |=> rd_data == $past(total_byte_count))
        else $error("total readback wrong");

    a_unmapped_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        bus_req.rd && !hit_ctrl && !hit_total |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");

    a_read_idle_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        !bus_req.rd |=> rd_data == 16'h0000)
        else $error("read data not idle");

endmodule : plb_checker
`default_nettype wire

// File: core/plb_pkg.sv
// ==========================================================
// Shared types of the loopback byte checker
package plb_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } plb_bus_req_t;

    // Returned loopback byte with its valid qualifier
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } plb_stream_t;

    // Sequence tracker states, one-hot
    typedef enum logic [2:0] {
        PLB_IDLE   = 3'b001,
        PLB_HUNT   = 3'b010,
        PLB_LOCKED = 3'b100
    } plb_sync_state_t;

endpackage : plb_pkg

// File: core/plb_regs.svh
`ifndef PLB_REGS_SVH
`define PLB_REGS_SVH

// ==========================================================
// Register offsets
`define PLB_ADDR_W          8
`define PLB_DATA_W          16
`define PLB_ADDR_CTRL       8'h39
`define PLB_ADDR_TOTAL      8'h3A

// ==========================================================
// Control and status field positions
`define PLB_BIT_ENABLE      0
`define PLB_BIT_MODE        1
`define PLB_BIT_OVERFLOW    2
`define PLB_BIT_LOCKED      4
`define PLB_BIT_SYNC_LOST   5
`define PLB_BIT_SNAP        7
`define PLB_BIT_CLEAR       8
`define PLB_ERR_LSB         7
`define PLB_ERR_MSB         14

// ==========================================================
// Reset values and limits
`define PLB_CTRL_RESET      16'h0000
`define PLB_TOTAL_RESET     16'h0000
`define PLB_ERR_RESET       8'h00
`define PLB_ERR_MAX         16'h00FF
`define PLB_TOTAL_MAX       16'hFFFF

// ==========================================================
// Sequence tracking counts, in bytes
`define PLB_LOCK_BYTES      4
`define PLB_LOSS_BYTES      4

`endif

// File: core/plb_seq_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "plb_regs.svh"

module plb_seq_sync #(
    parameter int LOCK_BYTES = `PLB_LOCK_BYTES,
    parameter int LOSS_BYTES = `PLB_LOSS_BYTES
) (
    input  wire logic                ref_clk,
    input  wire logic                reset,
    input  wire logic                enable,
    input  wire plb_pkg::plb_stream_t rx,
    output var  logic                byte_err,
    output var  logic                locked,
    output var  logic                sync_lost_evt
);

    // ==========================================================
    // Byte predictor: x^15 + x^14 + 1, first bit in the MSB
    function automatic logic [7:0] plb_predict(input logic [15:0] hist);
        logic [15:0] h;
        logic [7:0]  p;
        h = hist;
        p = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            p[i] = h[13] ^ h[14];
            h    = {h[14:0], p[i]};
        end
        return p;
    endfunction : plb_predict

    plb_pkg::plb_sync_state_t state;
    plb_pkg::plb_sync_state_t next_state;
    logic [15:0]              hist;
    logic [1:0]               primed;
    logic [7:0]               run_cnt;

    // ==========================================================
    // Compare the received byte with the prediction
    wire logic [7:0] expect_byte = plb_predict(hist);
    wire logic       matched     = (expect_byte == rx.data);
    wire logic       take        = enable && rx.valid;
    wire logic       hunt_ok     = (primed == 2'h2) && matched;
    wire logic       lock_hit    = hunt_ok && (run_cnt == 8'(LOCK_BYTES - 1));
    wire logic       loss_hit    = !matched && (run_cnt == 8'(LOSS_BYTES - 1));
    // Locked tracking runs on its own prediction so one bad byte counts once
    wire logic [7:0] hist_in     = state[2] ? expect_byte : rx.data;

    // Next state selection
    always_comb begin
        next_state = state;
        if (!enable) begin
            next_state = plb_pkg::PLB_IDLE;
        end else begin
            unique case (state)
                plb_pkg::PLB_IDLE:   next_state = plb_pkg::PLB_HUNT;
                plb_pkg::PLB_HUNT:   if (take && lock_hit) next_state = plb_pkg::PLB_LOCKED;
                plb_pkg::PLB_LOCKED: if (take && loss_hit) next_state = plb_pkg::PLB_HUNT;
                default:             next_state = plb_pkg::PLB_IDLE;
            endcase
        end
    end

    // State and history registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state   <= plb_pkg::PLB_IDLE;
            hist    <= 16'h0000;
            primed  <= 2'h0;
            run_cnt <= 8'h00;
        end else begin
            state <= next_state;
            if (!enable || state[0]) begin
                primed  <= 2'h0;
                run_cnt <= 8'h00;
            end else if (take) begin
                hist <= {hist[7:0], hist_in};
                if (primed != 2'h2) primed <= primed + 2'h1;
                if (state[1]) run_cnt <= (hunt_ok && !lock_hit) ? run_cnt + 8'h01 : 8'h00;
                else          run_cnt <= (!matched && !loss_hit) ? run_cnt + 8'h01 : 8'h00;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            byte_err      <= 1'b0;
            locked        <= 1'b0;
            sync_lost_evt <= 1'b0;
        end else begin
            byte_err      <= take && state[2] && !matched;
            locked        <= next_state[2];
            sync_lost_evt <= take && state[2] && loss_hit && enable;
        end
    end

endmodule : plb_seq_sync
`default_nettype wire

// File: test/plb_loop_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Reverse loop returning the sent sequence, prompt or slow
module plb_loop_model #(
    parameter logic [14:0] SEED = 15'h5A5A // Arbitrary nonzero start
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 run,
    input  wire logic                 slow,
    input  wire logic [7:0]           err_mask,
    output var  plb_pkg::plb_stream_t rx
);
    logic [14:0] lfsr;
    logic [14:0] next_lfsr;
    logic [7:0]  next_byte;
    logic        phase;
    logic        fire;

    // Eight steps of x^15+x^14+1, first bit into bit 7
    always_comb begin
        next_lfsr = lfsr;
        next_byte = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            next_byte[i] = next_lfsr[14] ^ next_lfsr[13];
            next_lfsr    = {next_lfsr[13:0], next_byte[i]};
        end
    end

    // Slow mode sends every other cycle
    assign fire = run && (!slow || phase);

    // Byte launch; idle data toggles so stale bytes never look valid
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lfsr  <= SEED;
            phase <= 1'b0;
            rx    <= '0;
        end else begin
            phase    <= ~phase;
            rx.valid <= fire;
            if (fire) begin
                lfsr    <= next_lfsr;
                rx.data <= next_byte ^ err_mask;
            end else begin
                rx.data <= ~rx.data;
            end
        end
    end
endmodule : plb_loop_model

`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "plb_regs.svh"

module tb_top;
    logic                  ref_clk  = 1'b0;
    logic                  reset    = 1'b1;
    plb_pkg::plb_bus_req_t bus_req  = '0;
    plb_pkg::plb_stream_t  rx;
    logic [15:0]           rd_data;
    logic                  run      = 1'b0;
    logic                  slow     = 1'b0;
    logic [7:0]            err_mask = 8'h00;
    logic                  rd_q     = 1'b0;
    logic                  en_model = 1'b0;
    logic [15:0]           snap;
    logic [15:0]           exp_q[$];
    int                    error_cnt   = 0;
    int                    checks_done = 0;
    int                    byte_cnt    = 0;
    int                    seed;

    // ==========================================================
    // Clock, design and far side
    always #12.5 ref_clk = ~ref_clk;

    plb_checker #(.LOCK_BYTES(4), .LOSS_BYTES(4)) dut_u (
        .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req), .rx(rx), .rd_data(rd_data));

    plb_loop_model loop_u (
        .ref_clk(ref_clk), .reset(reset), .run(run), .slow(slow),
        .err_mask(err_mask), .rx(rx));

    // ==========================================================
    // Compare, bus cycles, error injection, verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        if (addr == `PLB_ADDR_CTRL) en_model <= data[`PLB_BIT_ENABLE];
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] addr, input logic [15:0] exp);
        @(posedge ref_clk);
        bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(exp);
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
    endtask : bus_rd

    task automatic inject(input int n);
        @(posedge ref_clk);
        err_mask <= 8'($urandom_range(1, 255));
        repeat (n) @(posedge ref_clk);
        err_mask <= 8'h00;
    endtask : inject

    task automatic final_report;
        if (exp_q.size() != 0) error_cnt++;
        $display("Checks done: %0d, errors: %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Read results against oldest note; counts accepted bytes
    always @(posedge ref_clk) begin
        rd_q <= bus_req.rd;
        if (rd_q) begin
            check(rd_data, exp_q.size() ? exp_q.pop_front() : 16'hXXXX);
        end else if (rd_data !== 16'h0000) begin
            check(rd_data, 16'h0000);
        end
        if (rx.valid === 1'b1 && en_model) byte_cnt++;
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = $urandom(94);
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        bus_rd(`PLB_ADDR_CTRL, 16'h0000);
        bus_rd(`PLB_ADDR_TOTAL, 16'h0000);
        bus_rd(8'h50, 16'h0000);
        bus_wr(8'h50, 16'hFFFF);
        bus_wr(`PLB_ADDR_TOTAL, 16'hFFFF);
        bus_rd(`PLB_ADDR_TOTAL, 16'h0000);
        bus_wr(`PLB_ADDR_CTRL, 16'h804B);
        bus_rd(`PLB_ADDR_CTRL, 16'h0003);
        bus_wr(`PLB_ADDR_CTRL, 16'h0001);
        bus_rd(`PLB_ADDR_CTRL, 16'h0001);
        slow <= 1'b1;
        run  <= 1'b1;
        repeat (30) @(posedge ref_clk);
        bus_rd(`PLB_ADDR_CTRL, 16'h0011);
        slow <= 1'b0;
        repeat (3) begin
            inject(1);
            repeat (5 + $urandom_range(0, 15)) @(posedge ref_clk);
        end
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_wr(`PLB_ADDR_CTRL, 16'h0181);
        bus_rd(`PLB_ADDR_CTRL, 16'h0191);
        bus_rd(`PLB_ADDR_TOTAL, 16'(byte_cnt));
        byte_cnt = 0;
        run <= 1'b1;
        repeat (50) @(posedge ref_clk);
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_wr(`PLB_ADDR_CTRL, 16'h0081);
        snap = 16'(byte_cnt);
        bus_rd(`PLB_ADDR_TOTAL, snap);
        bus_rd(`PLB_ADDR_CTRL, 16'h0011);
        run <= 1'b1;
        repeat (20) @(posedge ref_clk);
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_rd(`PLB_ADDR_TOTAL, snap);
        run <= 1'b1;
        repeat (10) @(posedge ref_clk);
        inject(4);
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_rd(`PLB_ADDR_CTRL, 16'h0021);
        bus_rd(`PLB_ADDR_CTRL, 16'h0001);
        bus_wr(`PLB_ADDR_CTRL, 16'h0180);
        run <= 1'b1;
        repeat (30) @(posedge ref_clk);
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_wr(`PLB_ADDR_CTRL, 16'h0080);
        bus_rd(`PLB_ADDR_TOTAL, 16'h0000);
        bus_rd(`PLB_ADDR_CTRL, 16'h0000);
        bus_wr(`PLB_ADDR_CTRL, 16'h0181);
        run <= 1'b1;
        repeat (350) begin
            repeat (190 + $urandom_range(0, 16)) @(posedge ref_clk);
            inject(1);
        end
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_wr(`PLB_ADDR_CTRL, 16'h0081);
        bus_rd(`PLB_ADDR_TOTAL, 16'hFFFF);
        bus_rd(`PLB_ADDR_CTRL, 16'h7F95);
        // Continuous mode: both saturated counters wrap on the next event
        bus_wr(`PLB_ADDR_CTRL, 16'h0003);
        byte_cnt = 0;
        run <= 1'b1;
        repeat (10) @(posedge ref_clk);
        inject(1);
        repeat (5) @(posedge ref_clk);
        run <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus_wr(`PLB_ADDR_CTRL, 16'h0083);
        bus_rd(`PLB_ADDR_TOTAL, 16'(byte_cnt - 1));
        bus_rd(`PLB_ADDR_CTRL, 16'h0017);
        repeat (3) @(posedge ref_clk);
        final_report();
    end
endmodule : tb_top

`default_nettype wire
